// ### design/mopc_params.svh
// Purpose: named constants for the momentary output pulse control
// Assumes: register offsets are holding-register references
// Notes:   included by every design file except the package
`ifndef MOPC_PARAMS_SVH
`define MOPC_PARAMS_SVH

// holding-register references of the momentary control group
`define MOPC_ADDR_EXECUTE    16'hA0EC
`define MOPC_ADDR_PW_HIGH    16'hA0ED
`define MOPC_ADDR_PW_LOW     16'hA0EE
`define MOPC_ADDR_SPARE      16'hA0EF
`define MOPC_ADDR_SEL_MASK   16'hA0F0
`define MOPC_ADDR_CONF_MASK  16'hA0F1
`define MOPC_ADDR_DURATION   16'hEFEE

// execute codes
`define MOPC_EXEC_RUN        16'h0001
`define MOPC_EXEC_NONE       16'h0000

// factory password pair: two spaces per word
`define MOPC_PW_DEFAULT      16'h2020

// legal duration range in line cycles, and its reset value
`define MOPC_DUR_MIN         16'h0005
`define MOPC_DUR_MAX         16'h003C
`define MOPC_DUR_RESET       16'h0005

// mask layout: trip, close, outputs 1..8 in bits 0..9
`define MOPC_NUM_OUT         10
`define MOPC_MASK_RESET      16'h0000
`define MOPC_ZERO16          16'h0000

// timing: clock period and line periods in ns
`define MOPC_CLK_PERIOD_NS   4
`define MOPC_LINE50_NS       20000000
`define MOPC_LINE60_NS       16666667
`define MOPC_CYC_LINE50      (`MOPC_LINE50_NS / `MOPC_CLK_PERIOD_NS)
`define MOPC_CYC_LINE60      (`MOPC_LINE60_NS / `MOPC_CLK_PERIOD_NS)

`endif

// ### design/mopc_pkg.sv
// Purpose: shared types of the momentary output pulse control
// Assumes: nothing beyond the params header
// Notes:   types only; numbers live in the params header
package mopc_pkg;

   // pulse sequencer states
   typedef enum logic {
      MOPC_IDLE,
      MOPC_PULSING
   } mopc_state_t;

endpackage

// ### design/mopc_line_tick.sv
// Purpose: one-cycle tick at every power-line period
// Assumes: sel_60hz is already synchronised to clk
// Notes:   restart realigns the period so a pulse is exactly n periods
`timescale 1ns/1ps
`include "mopc_params.svh"

module mopc_line_tick #(
   parameter int unsigned CYC_50 = `MOPC_CYC_LINE50, // clocks per 50 Hz cycle
   parameter int unsigned CYC_60 = `MOPC_CYC_LINE60  // clocks per 60 Hz cycle
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // control
   input  wire logic sel_60hz, // 1 selects the 60 Hz period
   input  wire logic restart,  // start a fresh period
   // result
   output logic      tick      // last clock of a line period
);

   logic [31:0] cnt_r;   // clocks elapsed in the current period
   logic [31:0] cnt_nxt;
   logic [31:0] last;    // final count of the chosen period

   // period end; a frequency change takes effect at once, in the current period
   always_comb begin
      last = sel_60hz ? 32'(CYC_60 - 1) : 32'(CYC_50 - 1);
      tick = (cnt_r == last) && !restart;
      if (restart || tick) begin
         cnt_nxt = 32'h0000_0000;
      end else begin
         cnt_nxt = cnt_r + 32'h0000_0001;
      end
   end

   // period counter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r <= 32'h0000_0000;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

endmodule

// ### design/mopc_ctrl.sv
// Purpose: momentary pulse control of the relay's physical outputs
// Assumes: register port is driven by the fieldbus front end on clk
// Notes:   one shared pulse timer; a new command replaces a running one
//
// Behaviour
// - chosen outputs energised exactly programmed duration
// - pulse is momentary, never latched
// - duration in line cycles, accept 5..60
// - pulse time equals cycles times line period
// - duration register writable over the fieldbus
// - execute: 1 runs command, 0 does nothing
// - password in two words, left pair first
// - factory password reads 2020 hex per word
// - mask bits: trip, close, outputs 1..8
// - mask bit 1 pulses, 0 leaves alone
// - confirm mask mirrors the select mask
// - pulse only outputs set in both masks
// - act at once, no command queue
`timescale 1ns/1ps
`include "mopc_params.svh"

module mopc_ctrl
   import mopc_pkg::*;
#(
   parameter int unsigned       CYC_50      = `MOPC_CYC_LINE50,
   parameter int unsigned       CYC_60      = `MOPC_CYC_LINE60,
   parameter logic [9:0]        OUT_PRESENT = 10'h3FF // fitted outputs
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // holding-register access from the fieldbus front end
   input  wire logic        reg_wr,     // write strobe, one cycle
   input  wire logic        reg_rd,     // read strobe, one cycle
   input  wire logic [15:0] reg_addr,   // register reference
   input  wire logic [15:0] reg_wdata,  // write word
   output logic      [15:0] reg_rdata,  // read word, registered
   output logic             reg_ack,    // access done, one cycle
   output logic             reg_err,    // unmapped or refused, with ack
   // unit configuration
   input  wire logic        line_60hz_pin, // rated line 60 Hz when high
   input  wire logic [15:0] act_pw_high,   // active password, left pair
   input  wire logic [15:0] act_pw_low,    // active password, right pair
   // physical outputs
   output logic [9:0]       pulse_out,   // energise drive per output
   output logic             pulse_busy,  // a pulse is running
   output logic             cmd_refused  // execute refused, one cycle
);

   // staged command words
   logic [15:0] pw_high_r, pw_high_nxt;   // left password pair
   logic [15:0] pw_low_r,  pw_low_nxt;    // right password pair
   logic [15:0] sel_r,     sel_nxt;       // select mask
   logic [15:0] conf_r,    conf_nxt;      // confirm mask
   logic [15:0] dur_r,     dur_nxt;       // duration in line cycles
   // bus answer
   logic [15:0] rdata_nxt;
   logic        ack_nxt;
   logic        err_nxt;
   // pulse sequencer
   mopc_state_t state_r, state_nxt;
   logic [9:0]  out_r,   out_nxt;         // outputs being pulsed
   logic [15:0] left_r,  left_nxt;        // line cycles still to run
   logic        refused_r, refused_nxt;
   // line-frequency strap synchroniser
   logic        sync1_r, sync2_r, sync3_r;
   logic        sel60_r, sel60_nxt;
   // decode
   logic        exec_wr;
   logic        pw_ok;
   logic [9:0]  pick;
   logic        dur_ok;
   logic        tick;
   logic        restart;

   // write decode and command evaluation
   always_comb begin
      exec_wr = reg_wr && (reg_addr == `MOPC_ADDR_EXECUTE)
                && (reg_wdata == `MOPC_EXEC_RUN);
      pw_ok   = (pw_high_r == act_pw_high)
                && (pw_low_r == act_pw_low);
      // both masks must agree per bit; absent and reserved bits drop out
      pick    = sel_r[9:0] & conf_r[9:0] & OUT_PRESENT;
      dur_ok  = (reg_wdata >= `MOPC_DUR_MIN)
                && (reg_wdata <= `MOPC_DUR_MAX);
   end

   // register writes; execute itself stores nothing and reads back 0
   always_comb begin
      pw_high_nxt = pw_high_r;
      pw_low_nxt  = pw_low_r;
      sel_nxt     = sel_r;
      conf_nxt    = conf_r;
      dur_nxt     = dur_r;
      if (reg_wr) begin
         unique case (reg_addr)
            `MOPC_ADDR_PW_HIGH:   pw_high_nxt = reg_wdata;
            `MOPC_ADDR_PW_LOW:    pw_low_nxt  = reg_wdata;
            `MOPC_ADDR_SEL_MASK:  sel_nxt     = reg_wdata;
            `MOPC_ADDR_CONF_MASK: conf_nxt    = reg_wdata;
            `MOPC_ADDR_DURATION: begin
               // out-of-range values are refused, old value kept
               if (dur_ok) begin
                  dur_nxt = reg_wdata;
               end
            end
            default: begin
               // execute, spare and unmapped words store nothing
            end
         endcase
      end
   end

   // read data and access answer
   always_comb begin
      rdata_nxt = `MOPC_ZERO16;
      err_nxt   = 1'b0;
      ack_nxt   = reg_wr || reg_rd;
      unique case (reg_addr)
         `MOPC_ADDR_EXECUTE:   rdata_nxt = `MOPC_EXEC_NONE;
         `MOPC_ADDR_PW_HIGH:   rdata_nxt = pw_high_r;
         `MOPC_ADDR_PW_LOW:    rdata_nxt = pw_low_r;
         `MOPC_ADDR_SPARE:     rdata_nxt = `MOPC_ZERO16;
         `MOPC_ADDR_SEL_MASK:  rdata_nxt = sel_r;
         `MOPC_ADDR_CONF_MASK: rdata_nxt = conf_r;
         `MOPC_ADDR_DURATION: begin
            rdata_nxt = dur_r;
            err_nxt   = reg_wr && !dur_ok;
         end
         default:              err_nxt   = 1'b1;
      endcase
      if (!ack_nxt) begin
         rdata_nxt = `MOPC_ZERO16;
         err_nxt   = 1'b0;
      end
   end

   // staged words and bus answer registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pw_high_r <= `MOPC_PW_DEFAULT;
         pw_low_r  <= `MOPC_PW_DEFAULT;
         sel_r     <= `MOPC_MASK_RESET;
         conf_r    <= `MOPC_MASK_RESET;
         dur_r     <= `MOPC_DUR_RESET;
         reg_rdata <= `MOPC_ZERO16;
         reg_ack   <= 1'b0;
         reg_err   <= 1'b0;
      end else begin
         pw_high_r <= pw_high_nxt;
         pw_low_r  <= pw_low_nxt;
         sel_r     <= sel_nxt;
         conf_r    <= conf_nxt;
         dur_r     <= dur_nxt;
         reg_rdata <= rdata_nxt;
         reg_ack   <= ack_nxt;
         reg_err   <= err_nxt;
      end
   end

   // strap follows only when the last two stages agree
   always_comb begin
      sel60_nxt = (sync2_r == sync3_r) ? sync3_r : sel60_r;
   end

   // three-stage synchroniser for the line-frequency strap
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
         sel60_r <= 1'b0;
      end else begin
         sync1_r <= line_60hz_pin;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         sel60_r <= sel60_nxt;
      end
   end

   // line-period timebase, realigned on every accepted command that picks an output
   mopc_line_tick #(
      .CYC_50 (CYC_50),
      .CYC_60 (CYC_60)
   ) u_tick (
      .clk      (clk),
      .rst      (rst),
      .sel_60hz (sel60_r),
      .restart  (restart),
      .tick     (tick)
   );

   // pulse sequencer: a new accepted command replaces the running one
   always_comb begin
      state_nxt   = state_r;
      out_nxt     = out_r;
      left_nxt    = left_r;
      refused_nxt = 1'b0;
      restart     = 1'b0;
      if (exec_wr && pw_ok && (pick != 10'h000)) begin
         // start at once, nothing is held back for later
         state_nxt = MOPC_PULSING;
         out_nxt   = pick;
         left_nxt  = dur_r;
         restart   = 1'b1;
      end else begin
         // bad password or empty mask: no output moves, but a running
         // pulse keeps counting so its length is not stretched
         refused_nxt = exec_wr && !pw_ok;
         unique case (state_r)
            MOPC_IDLE: begin
               out_nxt = 10'h000;
            end
            MOPC_PULSING: begin
               if (tick) begin
                  if (left_r == 16'h0001) begin
                     // pulse ends by itself; nothing stays latched
                     state_nxt = MOPC_IDLE;
                     out_nxt   = 10'h000;
                     left_nxt  = `MOPC_ZERO16;
                  end else begin
                     left_nxt = left_r - 16'h0001;
                  end
               end
            end
         endcase
      end
   end

   // sequencer registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r   <= MOPC_IDLE;
         out_r     <= 10'h000;
         left_r    <= `MOPC_ZERO16;
         refused_r <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         out_r     <= out_nxt;
         left_r    <= left_nxt;
         refused_r <= refused_nxt;
      end
   end

   // outputs straight from registers
   assign pulse_out   = out_r;
   assign pulse_busy  = (state_r == MOPC_PULSING);
   assign cmd_refused = refused_r;

endmodule

// ### verif/mopc_ctrl_props.sv
// Purpose: port-level checks of the momentary pulse control
// Assumes: line strap held steady around each command
// Notes:   staged words are shadowed from the write port
`timescale 1ns/1ps
`include "mopc_params.svh"
module mopc_ctrl_props #(
   parameter int unsigned CYC_50      = `MOPC_CYC_LINE50,
   parameter int unsigned CYC_60      = `MOPC_CYC_LINE60,
   parameter logic [9:0]  OUT_PRESENT = 10'h3FF
) (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // register port
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic        reg_ack,
   input wire logic        reg_err,
   // configuration and outputs
   input wire logic        line_60hz_pin,
   input wire logic [15:0] act_pw_high,
   input wire logic [15:0] act_pw_low,
   input wire logic [9:0]  pulse_out,
   input wire logic        pulse_busy,
   input wire logic        cmd_refused
);
   logic [15:0] pwh_r, pwl_r, sel_r, conf_r, dur_r; // shadow words
   logic [31:0] cnt_r, len_r;   // clocks of pulse so far, and goal
   logic [9:0]  want;           // outputs the staged masks ask for
   logic        run, go, fire;  // execute seen, accepted, with outputs
   assign want = sel_r[9:0] & conf_r[9:0] & OUT_PRESENT;
   assign run  = reg_wr && reg_addr == `MOPC_ADDR_EXECUTE
                 && reg_wdata == `MOPC_EXEC_RUN;
   assign go   = run && pwh_r == act_pw_high && pwl_r == act_pw_low;
   assign fire = go && want != 10'h000;
   // shadows follow writes; a fresh pulse restarts the count
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwh_r  <= `MOPC_PW_DEFAULT;
         pwl_r  <= `MOPC_PW_DEFAULT;
         sel_r  <= `MOPC_MASK_RESET;
         conf_r <= `MOPC_MASK_RESET;
         dur_r  <= `MOPC_DUR_RESET;
         cnt_r  <= '0;
         len_r  <= '0;
      end else begin
         if (reg_wr && reg_addr == `MOPC_ADDR_PW_HIGH) pwh_r <= reg_wdata;
         if (reg_wr && reg_addr == `MOPC_ADDR_PW_LOW) pwl_r <= reg_wdata;
         if (reg_wr && reg_addr == `MOPC_ADDR_SEL_MASK) sel_r <= reg_wdata;
         if (reg_wr && reg_addr == `MOPC_ADDR_CONF_MASK) conf_r <= reg_wdata;
         if (reg_wr && reg_addr == `MOPC_ADDR_DURATION
             && reg_wdata >= `MOPC_DUR_MIN && reg_wdata <= `MOPC_DUR_MAX)
            dur_r <= reg_wdata;
         if (fire) begin
            cnt_r <= '0;
            len_r <= dur_r * (line_60hz_pin ? CYC_60 : CYC_50);
         end else if (pulse_busy)
            cnt_r <= cnt_r + 1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_start;
      fire;
   endsequence
   sequence s_drive;
      pulse_busy && !cmd_refused && pulse_out == $past(want);
   endsequence
   ack_follows_a: assert property ((reg_wr || reg_rd) |=> reg_ack)
      else $error("access not answered");
   ack_cause_a: assert property (reg_ack |-> $past(reg_wr || reg_rd))
      else $error("answer without access");
   dur_range_a: assert property (reg_wr && reg_addr == `MOPC_ADDR_DURATION
      && (reg_wdata < `MOPC_DUR_MIN || reg_wdata > `MOPC_DUR_MAX)
      |=> reg_ack && reg_err)
      else $error("bad duration taken");
   mask_and_a: assert property (s_start |=> s_drive)
      else $error("outputs differ from masks");
   refuse_a: assert property (run && !go |=> cmd_refused)
      else $error("wrong password not refused");
   exec_zero_a: assert property (reg_wr && reg_addr == `MOPC_ADDR_EXECUTE
      && reg_wdata == `MOPC_EXEC_NONE |=> !cmd_refused && !$rose(pulse_busy))
      else $error("zero execute acted");
   pulse_len_a: assert property ($fell(pulse_busy) |-> cnt_r == len_r)
      else $error("pulse length wrong");
   momentary_a: assert property (!pulse_busy |-> pulse_out == 10'h000)
      else $error("output left on");
   pulse_hold_a: assert property (pulse_busy && $past(pulse_busy)
      && !$past(fire) |-> $stable(pulse_out))
      else $error("output changed mid pulse");
endmodule
bind mopc_ctrl mopc_ctrl_props #(
   .CYC_50(CYC_50), .CYC_60(CYC_60), .OUT_PRESENT(OUT_PRESENT)
) u_props (
   .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .reg_ack(reg_ack), .reg_err(reg_err), .line_60hz_pin(line_60hz_pin),
   .act_pw_high(act_pw_high), .act_pw_low(act_pw_low),
   .pulse_out(pulse_out), .pulse_busy(pulse_busy),
   .cmd_refused(cmd_refused)
);

// ### verif/mopc_host_model.sv
// Purpose: fieldbus host stand-in on the holding-register port
// Assumes: one access at a time, strobe one clock wide
// Notes:   released address and data show the inverse of their last value; strobes drop to 0
`timescale 1ns/1ps
`include "mopc_params.svh"
module mopc_host_model (
   // clock
   input  wire logic        clk,
   // register port towards the device
   output logic             reg_wr,
   output logic             reg_rd,
   output logic [15:0]      reg_addr,
   output logic [15:0]      reg_wdata,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_ack,
   input  wire logic        reg_err
);
   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 16'h0000;
      reg_wdata = 16'h0000;
   end
   // strobe for one clock, take the answer once it has settled
   task automatic xfer(input logic wr, input logic [15:0] a, v,
                       output logic [15:0] rdata, output logic err);
      @(posedge clk);
      #1;
      reg_wr    = wr;
      reg_rd    = !wr;
      reg_addr  = a;
      reg_wdata = v;
      @(posedge clk);
      #1;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~v;
      rdata     = reg_ack ? reg_rdata : 16'hxxxx;
      err       = reg_ack ? reg_err : 1'bx;
   endtask
   // stage the block of words, then execute in a write of its own
   task automatic command(input logic [15:0] pwh, pwl, sel, conf);
      logic [15:0] d;
      logic        e;
      xfer(1'b1, `MOPC_ADDR_PW_HIGH, pwh, d, e);
      xfer(1'b1, `MOPC_ADDR_PW_LOW, pwl, d, e);
      xfer(1'b1, `MOPC_ADDR_SPARE, `MOPC_ZERO16, d, e);
      xfer(1'b1, `MOPC_ADDR_SEL_MASK, sel, d, e);
      xfer(1'b1, `MOPC_ADDR_CONF_MASK, conf, d, e);
      xfer(1'b1, `MOPC_ADDR_EXECUTE, `MOPC_EXEC_RUN, d, e);
   endtask
endmodule

// ### verif/tb_mopc_ctrl.sv
// Purpose: register-level tests of the momentary pulse control
// Assumes: line periods shortened to 20 and 16 clocks
// Notes:   output 7 left unfitted to show absent bits ignored
`timescale 1ns/1ps
`include "mopc_params.svh"
module tb_mopc_ctrl;
   localparam logic [9:0] FIT = 10'h2FF; // fitted outputs
   logic        clk, rst, wr, rd, ack, err, hz60, busy, refused, e;
   logic [15:0] addr, wdata, rdata, pwh, pwl, d;
   logic [9:0]  pout;
   int          mismatches, checks, cycles, n;
   mopc_host_model host (.clk(clk), .reg_wr(wr), .reg_rd(rd),
      .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
      .reg_ack(ack), .reg_err(err));
   mopc_ctrl #(.CYC_50(20), .CYC_60(16), .OUT_PRESENT(FIT)) dut (
      .clk(clk), .rst(rst), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
      .reg_wdata(wdata), .reg_rdata(rdata), .reg_ack(ack), .reg_err(err),
      .line_60hz_pin(hz60), .act_pw_high(pwh), .act_pw_low(pwl),
      .pulse_out(pout), .pulse_busy(busy), .cmd_refused(refused));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // a hang is cut short well past the longest test sequence
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         mismatches++;
         $display("mismatch at %0t: run too long", $time);
         test_done();
      end
   end
   task chk(input bit ok, input string m);
      checks++;
      if (!ok) begin
         mismatches++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task rdc(input logic [15:0] a, x, input logic xe, input string m);
      host.xfer(1'b0, a, 16'h0000, d, e);
      chk(d === x && e === xe, m);
   endtask
   task wrc(input logic [15:0] a, v, input logic xe, input string m);
      host.xfer(1'b1, a, v, d, e);
      chk(e === xe, m);
   endtask
   // command a pulse, then count the clocks it stands
   task pulse(input logic [15:0] s, c, input logic [9:0] x, input int len);
      host.command(16'h2020, 16'h2020, s, c);
      chk(pout === x && refused === 1'b0, "pulse outputs");
      n = 0;
      while (busy === 1'b1 && n < 2000) begin
         @(posedge clk);
         #1 n++;
      end
      chk(n == len && pout === 10'h000, "pulse length");
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      {rst, hz60, pwh, pwl} = {2'b10, 16'h2020, 16'h2020};
      {cycles, mismatches, checks} = '0;
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      rdc(`MOPC_ADDR_PW_HIGH, 16'h2020, 1'b0, "pw high");
      rdc(`MOPC_ADDR_PW_LOW, 16'h2020, 1'b0, "pw low");
      rdc(`MOPC_ADDR_SEL_MASK, 16'h0000, 1'b0, "select reset");
      rdc(16'hA0F2, 16'h0000, 1'b1, "unmapped read");
      $display("test reset values done");
      wrc(`MOPC_ADDR_DURATION, 16'h0004, 1'b1, "dur 4");
      wrc(`MOPC_ADDR_DURATION, 16'h003D, 1'b1, "dur 61");
      wrc(`MOPC_ADDR_DURATION, 16'h003C, 1'b0, "dur 60");
      rdc(`MOPC_ADDR_DURATION, 16'h003C, 1'b0, "dur kept");
      wrc(`MOPC_ADDR_DURATION, 16'h0005, 1'b0, "dur 5");
      wrc(`MOPC_ADDR_CONF_MASK, 16'hFC80, 1'b0, "conf write");
      rdc(`MOPC_ADDR_CONF_MASK, 16'hFC80, 1'b0, "conf read");
      $display("test register access done");
      pulse(16'h0080, 16'h0080, 10'h080, 100);
      pulse(16'h03FF, 16'h0155, 10'h055, 100);
      pulse(16'hFC00, 16'hFC00, 10'h000, 0);
      $display("test pulses done");
      wrc(`MOPC_ADDR_SEL_MASK, 16'h0080, 1'b0, "sel");
      wrc(`MOPC_ADDR_EXECUTE, 16'h0000, 1'b0, "exec 0");
      chk(busy === 1'b0 && refused === 1'b0, "exec 0 acted");
      rdc(`MOPC_ADDR_EXECUTE, 16'h0000, 1'b0, "exec read");
      pwl = 16'h4142;
      host.command(16'h2020, 16'h2020, 16'h0080, 16'h0080);
      chk(refused === 1'b1 && pout === 10'h000, "refusal");
      pwl = 16'h2020;
      $display("test refusal done");
      host.command(16'h2020, 16'h2020, 16'h0080, 16'h0080);
      repeat (10) @(posedge clk);
      #1 chk(busy === 1'b1 && pout === 10'h080, "first pulse");
      pulse(16'h0004, 16'h0004, 10'h004, 100);
      $display("test replace done");
      hz60 = 1'b1;
      wrc(`MOPC_ADDR_DURATION, 16'h0006, 1'b0, "dur 6");
      repeat (8) @(posedge clk);
      pulse(16'h0003, 16'h0003, 10'h003, 96);
      $display("test line rate done");
      test_done();
   end
endmodule
